// ==== rtl/rsa_pkg.sv ====
// Shared constants and the pointer advance function for the serial RTC/SRAM access link
package rsa_pkg;
  // Control codes (upper seven bits of the control byte)
  localparam logic [6:0] RSA_CODE_RTC    = 7'h6F; // 1101111
  localparam logic [6:0] RSA_CODE_NVM    = 7'h57; // 1010111
  // Address map
  localparam logic [7:0] RSA_RTC_FIRST   = 8'h00;
  localparam logic [7:0] RSA_RTC_LAST    = 8'h1F;
  localparam logic [7:0] RSA_SRAM_FIRST  = 8'h20;
  localparam logic [7:0] RSA_SRAM_LAST   = 8'h5F;
  localparam int         RSA_MEM_DEPTH   = 96;
  localparam logic [7:0] RSA_PTR_RESET   = 8'h00;
  // Bit counts
  localparam logic [3:0] RSA_BITS_BYTE   = 4'h8;
  // Master clock divider: half period of the serial clock in cycles
  localparam int         RSA_SYS_NS      = 10;
  localparam int         RSA_SCL_HALF_NS = 1250;
  localparam logic [7:0] RSA_HALF_CYC    =
    8'(RSA_SCL_HALF_NS / RSA_SYS_NS);

  // Pointer advance with per-block wrap
  function automatic logic [7:0] rsa_next_ptr(input logic [7:0] p);
    if (p == RSA_RTC_LAST) begin
      rsa_next_ptr = RSA_RTC_FIRST;
    end else if (p == RSA_SRAM_LAST) begin
      rsa_next_ptr = RSA_SRAM_FIRST;
    end else begin
      rsa_next_ptr = p + 8'h01;
    end
  endfunction : rsa_next_ptr
endpackage : rsa_pkg

// ==== rtl/rsa_link_if.sv ====
// Two-wire link joining the access slave and its master
`timescale 1ns/1ps
interface rsa_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain wire levels, pulled up when nobody drives low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input sda, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface : rsa_link_if

// ==== rtl/rsa_slave.sv ====
// Serial slave giving access to timekeeping registers and SRAM
// Behaviour
// (R1) Answer 1101111x; 1010111x is other space
// (R2) Serve accesses during nonvolatile write cycle
// (R3) Registers 0x00-0x1F, SRAM 0x20-0x5F
// (R4) SRAM usable during register update
// (R5) SRAM not initialised at reset
// (R6) Refuse all access on backup supply
// (R7) Acknowledge write control byte on ninth clock
// (R8) Load address byte into pointer, acknowledge
// (R9) Store data byte at pointer, acknowledge
// (R10) Address above 0x5F: no ack, no write
// (R11) Pointer follows last written location
// (R12) Each data byte: ack, store, increment
// (R13) Unlimited sequential write until Stop
// (R14) Pointer wraps within its block
// (R15) Current read returns last address plus one
// (R16) Read control: acknowledge then send byte
// (R17) Master no-ack and Stop ends driving
// (R18) One pointer shared with other space
// (R19) Ignore foreign control codes
`timescale 1ns/1ps
module rsa_slave
  import rsa_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  rsa_link_if.slave       link,
  input  wire logic       on_backup,
  input  wire logic       nvm_busy,
  input  wire logic       rtc_updating,
  output logic [7:0]      rd_addr,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_CACK = 3'b011,
    ST_RXB  = 3'b010,
    ST_RACK = 3'b110,
    ST_TXB  = 3'b111,
    ST_TACK = 3'b101
  } rsa_state_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_d;
    logic       sda_d;
    rsa_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       got_addr;
    logic       bad;
    logic [1:0] bk_s;
    logic       sda_o;
    logic       sda_oe;
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       busy;
  } rsa_slave_t;

  rsa_slave_t r;
  rsa_slave_t next_r;
  logic [7:0] mem [RSA_MEM_DEPTH]; // (R5) no reset applied
  logic [7:0] rd_data;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // Edge and condition detection on synchronised pins
  assign scl_rise = r.scl_s[1] & ~r.scl_d;
  assign scl_fall = ~r.scl_s[1] & r.scl_d;
  assign start_c  = r.scl_s[1] & r.scl_d & r.sda_d & ~r.sda_s[1];
  assign stop_c   = r.scl_s[1] & r.scl_d & ~r.sda_d & r.sda_s[1];
  assign rd_data  = (r.ptr <= RSA_SRAM_LAST) ? mem[r.ptr[6:0]] : 8'h00; // R3

  // Next state of the protocol engine
  always_comb begin
    next_r = r;
    next_r.scl_s  = {r.scl_s[0], link.scl};
    next_r.sda_s  = {r.sda_s[0], link.sda};
    next_r.scl_d  = r.scl_s[1];
    next_r.sda_d  = r.sda_s[1];
    next_r.bk_s   = {r.bk_s[0], on_backup}; // Supply flag synchroniser
    next_r.wr_stb = 1'b0;
    if (r.bk_s[1]) begin
      next_r.st     = ST_IDLE;  // (R6)
      next_r.sda_oe = 1'b0;
    end else if (start_c) begin
      next_r.st     = ST_CTRL;
      next_r.cnt    = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_r.st     = ST_IDLE;  // (R13) (R17)
      next_r.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        ST_IDLE: ;
        ST_CTRL, ST_RXB: begin
          if (scl_rise) begin
            next_r.sh  = {r.sh[6:0], r.sda_s[1]};
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == RSA_BITS_BYTE) begin
            next_r.cnt = 4'h0;
            if (r.st == ST_CTRL) begin
              next_r.got_addr = 1'b0;
              next_r.bad = 1'b0;
              if (r.sh[7:1] == RSA_CODE_RTC) begin
                next_r.st     = ST_CACK; // (R7) (R16)
                next_r.sda_oe = 1'b1;
                next_r.sda_o  = 1'b0;
              end else begin
                next_r.st = ST_IDLE;     // (R1) (R19)
              end
            end else if (!r.got_addr) begin
              next_r.got_addr = 1'b1;
              next_r.ptr = r.sh;         // (R8)
              next_r.bad = (r.sh > RSA_SRAM_LAST); // (R10)
              next_r.st  = ST_RACK;
              next_r.sda_oe = (r.sh <= RSA_SRAM_LAST);
              next_r.sda_o  = 1'b0;
            end else begin
              next_r.st     = ST_RACK;
              next_r.sda_oe = ~r.bad;    // (R10)
              next_r.sda_o  = 1'b0;
              if (!r.bad) begin
                next_r.wr_stb  = 1'b1;   // (R9) (R12) (R2) (R4)
                next_r.wr_addr = r.ptr;
                next_r.wr_data = r.sh;
                next_r.ptr     = rsa_next_ptr(r.ptr); // (R11) (R14)
              end
            end
          end
        end
        ST_CACK: begin
          if (scl_fall) begin
            if (r.sh[0]) begin
              next_r.st     = ST_TXB;    // (R16)
              next_r.sda_oe = ~rd_data[7];
              next_r.sda_o  = 1'b0;
              next_r.sh     = {rd_data[6:0], 1'b0};
              next_r.ptr    = rsa_next_ptr(r.ptr); // (R15) (R18)
              next_r.cnt    = 4'h1;
            end else begin
              next_r.st     = ST_RXB;
              next_r.sda_oe = 1'b0;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            next_r.st     = ST_RXB;
            next_r.sda_oe = 1'b0;
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            if (r.cnt == RSA_BITS_BYTE) begin
              next_r.st     = ST_TACK;
              next_r.sda_oe = 1'b0;
            end else begin
              next_r.sda_oe = ~r.sh[7];
              next_r.sh     = {r.sh[6:0], 1'b0};
              next_r.cnt    = r.cnt + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            next_r.sh[0] = r.sda_s[1];   // Master ack sample
          end else if (scl_fall) begin
            if (!r.sh[0]) begin
              next_r.st     = ST_TXB;    // Sequential read
              next_r.sda_oe = ~rd_data[7];
              next_r.sh     = {rd_data[6:0], 1'b0};
              next_r.ptr    = rsa_next_ptr(r.ptr); // (R14)
              next_r.cnt    = 4'h1;
            end else begin
              next_r.st = ST_IDLE;       // (R17)
            end
          end
        end
        default: next_r.st = ST_IDLE;
      endcase
    end
    next_r.busy = (next_r.st != ST_IDLE);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r       <= '0;
      r.scl_s <= 2'b11;
      r.sda_s <= 2'b11;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.ptr   <= RSA_PTR_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Memory write port
  always_ff @(posedge sys_clk) begin
    if (next_r.wr_stb) begin
      mem[next_r.wr_addr[6:0]] <= next_r.wr_data; // (R9)
    end
  end

  assign link.sda_s_o  = r.sda_o;
  assign link.sda_s_oe = r.sda_oe;
  assign rd_addr = r.ptr;
  assign wr_stb  = r.wr_stb;
  assign wr_addr = r.wr_addr;
  assign wr_data = r.wr_data;
  assign busy    = r.busy;
endmodule : rsa_slave

// ==== rtl/rsa_master.sv ====
// Serial master issuing writes and current-address reads
`timescale 1ns/1ps
module rsa_master
  import rsa_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  rsa_link_if.master      link,
  input  wire logic       req,
  input  wire logic       req_rd,
  input  wire logic [7:0] req_ctrl,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  input  wire logic       req_more,
  output logic            done,
  output logic            ack_ok,
  output logic [7:0]      rd_data,
  output logic            busy
);
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000, MS_STA = 3'b001, MS_BYTE = 3'b011,
    MS_ACK = 3'b010, MS_STO = 3'b110
  } rsa_mstate_t;

  typedef struct packed {
    rsa_mstate_t st;
    logic [7:0]  div;
    logic [1:0]  ph;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [1:0]  idx;
    logic        rd;
    logic        more;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic        scl;
    logic        sda;
    logic        ack_ok;
    logic        done;
    logic [7:0]  rd_data;
    logic [1:0]  sda_s;
    logic        busy;
  } rsa_master_t;

  rsa_master_t m;
  rsa_master_t next_m;
  logic        tick;

  // Four ticks per bit, so a tick is half of the clock's half period
  assign tick = (m.div == ((RSA_HALF_CYC + 8'h01) >> 1) - 8'h01);

  // Bit sequencer: control (R7), address (R8), data (R9) or read (R17)
  always_comb begin
    next_m       = m;
    next_m.done  = 1'b0;
    next_m.sda_s = {m.sda_s[0], link.sda};
    next_m.div   = tick ? 8'h00 : m.div + 8'h01;
    unique case (m.st)
      MS_IDLE: begin
        next_m.div = 8'h00;
        if (req) begin
          next_m.st   = MS_STA;
          next_m.ph   = 2'h0;
          next_m.rd   = req_rd;
          next_m.more = req_more;
          next_m.addr = req_addr;
          next_m.data = req_data;
          next_m.sh   = {req_ctrl[7:1], req_rd};
          next_m.idx  = 2'h0;
          next_m.ack_ok = 1'b1;
        end
      end
      MS_STA: if (tick) begin
        next_m.ph = m.ph + 2'h1;
        if (m.ph == 2'h0) next_m.sda = 1'b0;
        if (m.ph == 2'h1) begin
          next_m.scl = 1'b0;
          next_m.st  = MS_BYTE;
          next_m.cnt = 4'h0;
          next_m.ph  = 2'h0;
        end
      end
      MS_BYTE, MS_ACK: if (tick) begin
        next_m.ph = m.ph + 2'h1;
        if (m.ph == 2'h0) begin
          if (m.st == MS_BYTE) begin
            next_m.sda = (m.rd && m.idx != 2'h0) ? 1'b1 : m.sh[7];
          end else begin
            next_m.sda = (m.rd && m.idx == 2'h1) ? ~m.more : 1'b1;
          end
        end
        if (m.ph == 2'h1) next_m.scl = 1'b1;
        if (m.ph == 2'h2 && m.st == MS_BYTE) begin
          next_m.sh = {m.sh[6:0], m.sda_s[1]};
        end
        if (m.ph == 2'h2 && m.st == MS_ACK && !(m.rd && m.idx != 2'h0)) begin
          next_m.ack_ok = m.ack_ok & ~m.sda_s[1];
        end
        if (m.ph == 2'h3) begin
          next_m.scl = 1'b0;
          next_m.ph  = 2'h0;
          if (m.st == MS_BYTE) begin
            next_m.cnt = m.cnt + 4'h1;
            if (m.cnt == RSA_BITS_BYTE - 4'h1) next_m.st = MS_ACK;
          end else begin
            next_m.cnt = 4'h0;
            next_m.idx = m.idx + 2'h1;
            next_m.st  = MS_BYTE;
            if (m.rd && m.idx != 2'h0) next_m.rd_data = m.sh;
            if (m.idx == 2'h0) next_m.sh = m.addr;
            if (m.idx != 2'h0) next_m.sh = m.data; // Repeat data when more
            // Stop after a nack or after the last byte asked for
            if (!m.ack_ok || m.idx == 2'h3 ||
                (m.idx == 2'h2 && (m.rd || !m.more)) ||
                (m.idx == 2'h1 && m.rd && !m.more)) begin
              next_m.st = MS_STO;
            end
          end
        end
      end
      MS_STO: if (tick) begin
        next_m.ph = m.ph + 2'h1;
        if (m.ph == 2'h0) next_m.sda = 1'b0;
        if (m.ph == 2'h1) next_m.scl = 1'b1;
        if (m.ph == 2'h2) begin
          next_m.sda  = 1'b1;
          next_m.st   = MS_IDLE;
          next_m.done = 1'b1;
        end
      end
      default: next_m.st = MS_IDLE;
    endcase
    next_m.busy = (next_m.st != MS_IDLE);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      m       <= '0;
      m.scl   <= 1'b1;
      m.sda   <= 1'b1;
      m.sda_s <= 2'b11;
    end else begin
      m <= next_m;
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = ~m.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~m.sda;
  assign done    = m.done;
  assign ack_ok  = m.ack_ok;
  assign rd_data = m.rd_data;
  assign busy    = m.busy;
endmodule : rsa_master

// ==== sim/rsa_asserts.sv ====
// Wire-level checks of the slave side of the two-wire link
`timescale 1ns/1ps
module rsa_asserts
  import rsa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       idle;
  logic       rise;
  logic       start;
  logic       stop;
  logic [3:0] bcnt;
  logic [2:0] nbyte;
  logic [7:0] sh;
  logic [7:0] ctrl;
  logic [7:0] addr;
  logic [6:0] code;

  // Edge, start and stop decode on the resolved wires
  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign code  = ctrl[7:1];

  // Frame tracker: bit slot, byte number, captured bytes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle  <= 1'b1;
      bcnt  <= 4'h0;
      nbyte <= 3'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        idle  <= 1'b0;
        bcnt  <= 4'h0;
        nbyte <= 3'h0;
      end else if (stop) begin
        idle <= 1'b1;
      end else if (rise) begin
        if (bcnt == 4'h8) begin
          bcnt  <= 4'h0;
          nbyte <= nbyte + 3'h1;
        end else begin
          bcnt <= bcnt + 4'h1;
          sh   <= {sh[6:0], sda};
        end
        if (bcnt == 4'h7 && nbyte == 3'h0) ctrl <= {sh[6:0], sda};
        if (bcnt == 4'h7 && nbyte == 3'h1) addr <= {sh[6:0], sda};
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Ninth clock of a byte
  sequence ack_slot_s;
    rise && bcnt == 4'h8;
  endsequence

  hold_in_high_a: assert property (scl && scl_q |-> $stable(sda_s_oe))
    else $error("slave moved data while clock high");
  idle_release_a: assert property (idle |-> !sda_s_oe)
    else $error("slave drives data outside a frame");
  foreign_nack_a: assert property (ack_slot_s ##0 (nbyte == 3'h0 &&
      code != RSA_CODE_RTC && code != RSA_CODE_NVM) |-> !sda_s_oe)
    else $error("foreign control byte acknowledged");
  nvm_nack_a: assert property (ack_slot_s ##0
      (nbyte == 3'h0 && code == RSA_CODE_NVM) |-> !sda_s_oe)
    else $error("other space control byte acknowledged");
  addr_nack_a: assert property (ack_slot_s ##0 (nbyte != 3'h0 &&
      code == RSA_CODE_RTC && !ctrl[0] && addr > RSA_SRAM_LAST)
      |-> !sda_s_oe)
    else $error("byte acknowledged for address above SRAM");
  rd_release_a: assert property (ack_slot_s ##0
      (nbyte != 3'h0 && ctrl[0]) |-> !sda_s_oe)
    else $error("slave drives during master ack slot");
  wr_bits_quiet_a: assert property (rise && bcnt < 4'h8 &&
      (nbyte == 3'h0 || !ctrl[0]) |-> !sda_s_oe)
    else $error("slave drives during master data bits");
  ack_held_a: assert property ((ack_slot_s ##0 sda_s_oe)
      |-> sda_s_oe [*8])
    else $error("acknowledge not held while clock high");
endmodule : rsa_asserts

// ==== sim/rtcc_sram_i2c_access_tb.sv ====
// Self-checking bench: master and slave joined over the two-wire link
`timescale 1ns/1ps
module rtcc_sram_i2c_access_tb;
  logic       sys_clk, reset, on_backup, nvm_busy, rtc_updating;
  logic       req, req_rd, req_more, wr_stb, s_busy, done, ack_ok, m_busy;
  logic [7:0] req_ctrl, req_addr, req_data, rd_addr, wr_addr, wr_data;
  logic [7:0] rd_data, wa, wd;
  logic [7:0] n_wr = 8'h00;
  logic [7:0] n_seq;
  int         n_errors = 0;
  int         check_count = 0;

  rsa_link_if link();

  rsa_slave u_rsa_slave (.sys_clk(sys_clk), .reset(reset), .link(link),
    .on_backup(on_backup), .nvm_busy(nvm_busy),
    .rtc_updating(rtc_updating), .rd_addr(rd_addr), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data), .busy(s_busy));

  rsa_master u_rsa_master (.sys_clk(sys_clk), .reset(reset), .link(link),
    .req(req), .req_rd(req_rd), .req_ctrl(req_ctrl), .req_addr(req_addr),
    .req_data(req_data), .req_more(req_more), .done(done),
    .ack_ok(ack_ok), .rd_data(rd_data), .busy(m_busy));

  rsa_asserts u_rsa_asserts (.sys_clk(sys_clk), .reset(reset),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Store strobe monitor
  always @(posedge sys_clk) begin
    if (wr_stb === 1'b1) begin
      n_wr <= n_wr + 8'h01;
      wa   <= wr_addr;
      wd   <= wr_data;
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts and verdict
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // One request to the master, then wait for its completion pulse
  task automatic xfer(input logic r, input logic [7:0] c, a, d);
    int i;
    @(posedge sys_clk);
    #1;
    req      = 1'b1;
    req_rd   = r;
    req_ctrl = c;
    req_addr = a;
    req_data = d;
    @(posedge sys_clk);
    #1;
    req = 1'b0;
    check("master busy", 8'(m_busy), 8'h01);
    for (i = 0; i < 20000 && done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check("done", 8'(done), 8'h01);
    check("master idle", 8'(m_busy), 8'h00);
    repeat (8) @(posedge sys_clk);
    #1;
    check("slave idle", 8'(s_busy), 8'h00);
  endtask : xfer

  // Byte write with expected acknowledge, store and pointer
  task automatic wr_case(input logic [7:0] c, a, d, input logic bk, ea,
                         input logic [7:0] ep);
    logic [7:0] n0;
    n0 = n_wr;
    on_backup = bk;
    xfer(1'b0, c, a, d);
    check("ack", 8'(ack_ok), 8'(ea));
    if (ea) begin
      check("store addr", wa, a);
      check("store data", wd, d);
      check("store count", n_wr, n0 + 8'h01);
      check("pointer", rd_addr, ep);
    end else begin
      check("no store", n_wr, n0);
    end
    on_backup = 1'b0;
  endtask : wr_case

  // Hang guard
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {reset, on_backup, nvm_busy, rtc_updating, req, req_rd, req_more} = 7'h40;
    {req_ctrl, req_addr, req_data} = 24'h000000;
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    check("reset pointer", rd_addr, 8'h00);
    nvm_busy = 1'b1;
    rtc_updating = 1'b1;
    wr_case(8'hDE, 8'h1F, 8'h3C, 1'b0, 1'b1, 8'h00);
    wr_case(8'hDE, 8'h20, 8'hC3, 1'b0, 1'b1, 8'h21);
    wr_case(8'hDE, 8'h5F, 8'hA5, 1'b0, 1'b1, 8'h20);
    nvm_busy = 1'b0;
    rtc_updating = 1'b0;
    xfer(1'b1, 8'hDE, 8'h00, 8'h00);
    check("read ack", 8'(ack_ok), 8'h01);
    check("read data", rd_data, 8'hC3);
    check("read pointer", rd_addr, 8'h21);
    // Two-byte write from 0x5D, then two-byte read across the SRAM end
    n_seq = n_wr;
    req_more = 1'b1;
    xfer(1'b0, 8'hDE, 8'h5D, 8'h77);
    check("seq ack", 8'(ack_ok), 8'h01);
    check("seq count", n_wr, n_seq + 8'h02);
    check("seq addr", wa, 8'h5E);
    check("seq data", wd, 8'h77);
    check("seq pointer", rd_addr, 8'h5F);
    xfer(1'b1, 8'hDE, 8'h00, 8'h00);
    check("seq read ack", 8'(ack_ok), 8'h01);
    check("seq read data", rd_data, 8'hC3);
    check("seq read pointer", rd_addr, 8'h21);
    req_more = 1'b0;
    wr_case(8'hDE, 8'h60, 8'h55, 1'b0, 1'b0, 8'h00);
    wr_case(8'hA0, 8'h10, 8'h66, 1'b0, 1'b0, 8'h00);
    wr_case(8'hAE, 8'h10, 8'h66, 1'b0, 1'b0, 8'h00);
    wr_case(8'hDE, 8'h30, 8'h99, 1'b1, 1'b0, 8'h00);
    give_verdict();
  end
endmodule : rtcc_sram_i2c_access_tb
